// *** src/radio_state_control_config.sv ***
// Radio main control state machine with its configuration registers,
// reached over AXI4-Lite. Assumes all radio inputs come from logic on clk.
`timescale 1ns/100ps
`include "radio_cfg_defines.svh"
module radio_state_control_config (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [`ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   strobe_rx,
	input  wire logic                   strobe_tx,
	input  wire logic                   strobe_synth_on_ready_tx,
	input  wire logic                   strobe_idle,
	input  wire logic                   calibrate_strobe,
	input  wire logic                   rx_packet_done,
	input  wire logic                   tx_packet_done,
	input  wire logic                   rssi_below_threshold,
	input  wire logic                   packet_receiving,
	input  wire logic                   carrier_detected,
	input  wire logic                   sync_detected,
	output radio_cfg_pkg::radio_state_t radio_state,
	output logic                        synth_calibrating,
	output logic                        preamble_restart,
	output logic                        clear_channel,
	output logic [4:0]                  rx_atten_db,
	output logic                        loops_frozen,
	output logic [3:0]                  offset_gain_half_k,
	output logic                        offset_comp_enable,
	output logic [1:0]                  offset_limit_shift
);
	radio_cfg_pkg::top_state_t   q;
	radio_cfg_pkg::top_state_t   d;
	radio_cfg_pkg::radio_state_t go_state;
	logic                        go_req;
	logic                        ret_req;

	radio_ctl_if ctl ();

	synth_cal_policy u_cal (
		.clk (clk),
		.rst (rst),
		.ctl (ctl.cal)
	);

	offset_loop_ctl u_foc (
		.clk (clk),
		.rst (rst),
		.ctl (ctl.foc)
	);

	// Configuration fed to the helper units straight from the registers
	assign ctl.policy    = q.cal_cfg[`AUTOCAL_LSB +: 2];
	assign ctl.foc_cfg   = q.foc_cfg;
	assign ctl.rx_active = (q.state == radio_cfg_pkg::ST_RX);
	assign ctl.carrier   = carrier_detected;
	assign ctl.sync      = sync_detected;

	// Whole next state: bus slave, then radio state machine, then outputs
	always_comb begin
		d               = q;
		go_state        = radio_cfg_pkg::ST_IDLE;
		go_req          = 1'b0;
		ret_req         = 1'b0;
		ctl.auto_return = 1'b0;

		// Write address and data are taken in either order
		if (s_axi_awvalid && q.aw_rdy) begin
			d.aw_rdy  = 1'b0;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.w_rdy) begin
			d.w_rdy  = 1'b0;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end

		// Both halves held: commit one cycle later and answer
		if (!q.aw_rdy && !q.w_rdy && !q.b_vld) begin
			d.b_vld  = 1'b1;
			d.b_resp = `RESP_OKAY;
			unique case (q.aw_addr)
				`EXIT_ADDR: begin
					if (q.w_strb[0]) begin
						d.exit_cfg = q.w_data[7:0] & `EXIT_WMASK;
					end
				end
				`CALCFG_ADDR: begin
					if (q.w_strb[0]) begin
						d.cal_cfg = q.w_data[7:0] & `CALCFG_WMASK;
					end
				end
				// Bit six is stored as written; software keeps it at zero
				`FOC_ADDR: begin
					if (q.w_strb[0]) begin
						d.foc_cfg = q.w_data[7:0] & `FOC_WMASK;
					end
				end
				`STATUS_ADDR: begin
					d.b_resp = `RESP_OKAY; // Read-only, write ignored
				end
				default: begin
					d.b_resp = `RESP_SLVERR;
				end
			endcase
		end
		if (q.b_vld && s_axi_bready) begin
			d.b_vld  = 1'b0;
			d.aw_rdy = 1'b1;
			d.w_rdy  = 1'b1;
		end

		// Reads answer at the edge that takes the address
		if (s_axi_arvalid && q.ar_rdy) begin
			d.ar_rdy = 1'b0;
			d.r_vld  = 1'b1;
			d.r_resp = `RESP_OKAY;
			d.r_data = 32'h0000_0000;
			unique case (s_axi_araddr)
				`EXIT_ADDR:   d.r_data[7:0] = q.exit_cfg;
				`CALCFG_ADDR: d.r_data[7:0] = q.cal_cfg;
				`FOC_ADDR:    d.r_data[7:0] = q.foc_cfg;
				`STATUS_ADDR: d.r_data[7:0] = {q.cca, ctl.returns, q.state};
				default:      d.r_resp      = `RESP_SLVERR;
			endcase
		end
		if (q.r_vld && s_axi_rready) begin
			d.r_vld  = 1'b0;
			d.ar_rdy = 1'b1;
		end

		// Radio main state machine; strobes are one-cycle pulses
		d.preamble = 1'b0;
		unique case (q.state)
			radio_cfg_pkg::ST_IDLE: begin
				if (calibrate_strobe) begin
					d.state   = radio_cfg_pkg::ST_CAL;
					d.target  = radio_cfg_pkg::ST_IDLE;
					d.cal_cnt = 5'h00;
				end else if (strobe_rx) begin
					go_req   = 1'b1;
					go_state = radio_cfg_pkg::ST_RX;
				end else if (strobe_tx) begin
					go_req   = 1'b1;
					go_state = radio_cfg_pkg::ST_TX;
				end else if (strobe_synth_on_ready_tx) begin
					go_req   = 1'b1;
					go_state = radio_cfg_pkg::ST_SYNTH_ON_READY_TX;
				end
			end
			radio_cfg_pkg::ST_RX: begin
				if (strobe_idle) begin
					d.state = radio_cfg_pkg::ST_IDLE; // Manual, never calibrates
				end else if (rx_packet_done) begin
					unique case (q.exit_cfg[`RXOFF_LSB +: 2])
						2'h0: ret_req = 1'b1;
						2'h1: d.state = radio_cfg_pkg::ST_SYNTH_ON_READY_TX;
						2'h2: d.state = radio_cfg_pkg::ST_TX;
						2'h3: d.state = radio_cfg_pkg::ST_RX;
					endcase
				end
			end
			radio_cfg_pkg::ST_TX: begin
				if (strobe_idle) begin
					d.state = radio_cfg_pkg::ST_IDLE;
				end else if (tx_packet_done) begin
					unique case (q.exit_cfg[`TXOFF_LSB +: 2])
						2'h0: ret_req = 1'b1;
						2'h1: d.state = radio_cfg_pkg::ST_SYNTH_ON_READY_TX;
						2'h2: d.preamble = 1'b1;
						2'h3: d.state = radio_cfg_pkg::ST_RX;
					endcase
				end
			end
			radio_cfg_pkg::ST_SYNTH_ON_READY_TX: begin
				if (strobe_idle) begin
					d.state = radio_cfg_pkg::ST_IDLE;
				end else if (strobe_tx) begin
					d.state = radio_cfg_pkg::ST_TX;
				end else if (strobe_rx) begin
					d.state = radio_cfg_pkg::ST_RX;
				end
			end
			radio_cfg_pkg::ST_CAL: begin
				// Fixed calibration time, then on to the saved target
				if (q.cal_cnt == 5'(`CAL_CYCLES - 1)) begin
					d.state = q.target;
				end else begin
					d.cal_cnt = q.cal_cnt + 5'h01;
				end
			end
			default: begin
				d.state = radio_cfg_pkg::ST_IDLE; // Recover from a broken code
			end
		endcase

		if (go_req) begin
			if (ctl.on_exit) begin
				d.state   = radio_cfg_pkg::ST_CAL;
				d.target  = go_state;
				d.cal_cnt = 5'h00;
			end else begin
				d.state = go_state;
			end
		end

		if (ret_req) begin
			ctl.auto_return = 1'b1;
			if (ctl.on_return) begin
				d.state   = radio_cfg_pkg::ST_CAL;
				d.target  = radio_cfg_pkg::ST_IDLE;
				d.cal_cnt = 5'h00;
			end else begin
				d.state = radio_cfg_pkg::ST_IDLE;
			end
		end

		d.calibrating = (d.state == radio_cfg_pkg::ST_CAL);

		unique case (q.exit_cfg[`CCA_LSB +: 2])
			2'h0: d.cca = 1'b1;
			2'h1: d.cca = rssi_below_threshold;
			2'h2: d.cca = !packet_receiving;
			2'h3: d.cca = rssi_below_threshold && !packet_receiving;
		endcase

		unique case (q.cal_cfg[`ATTEN_LSB +: 2])
			2'h0: d.atten = 5'h00;
			2'h1: d.atten = 5'h06;
			2'h2: d.atten = 5'h0c;
			2'h3: d.atten = 5'h12;
		endcase
	end

	// Single state register; every field has a constant reset value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q             <= '0;
			q.exit_cfg    <= `EXIT_RESET;
			q.cal_cfg     <= `CALCFG_RESET;
			q.foc_cfg     <= `FOC_RESET;
			q.aw_rdy      <= 1'b1;
			q.w_rdy       <= 1'b1;
			q.ar_rdy      <= 1'b1;
			q.state       <= radio_cfg_pkg::ST_IDLE;
			q.target      <= radio_cfg_pkg::ST_IDLE;
			q.cca         <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// All outputs are flip-flop fields
	assign s_axi_awready      = q.aw_rdy;
	assign s_axi_wready       = q.w_rdy;
	assign s_axi_bvalid       = q.b_vld;
	assign s_axi_bresp        = q.b_resp;
	assign s_axi_arready      = q.ar_rdy;
	assign s_axi_rvalid       = q.r_vld;
	assign s_axi_rresp        = q.r_resp;
	assign s_axi_rdata        = q.r_data;
	assign radio_state        = q.state;
	assign synth_calibrating  = q.calibrating;
	assign preamble_restart   = q.preamble;
	assign clear_channel      = q.cca;
	assign rx_atten_db        = q.atten;
	assign loops_frozen       = ctl.frozen;
	assign offset_gain_half_k = ctl.gain;
	assign offset_comp_enable = ctl.enable;
	assign offset_limit_shift = ctl.shift;
endmodule // radio_state_control_config

// *** src/radio_cfg_defines.svh ***
// Register map, field positions, reset values and timing counts of the radio
// state control block. Assumes a byte-addressed 32-bit register bus.
`ifndef RADIO_CFG_DEFINES_SVH
`define RADIO_CFG_DEFINES_SVH

`define ADDR_W          18
// Register indexes; byte address is four times the index
`define EXIT_IDX        16'hdf13
`define CALCFG_IDX      16'hdf14
`define FOC_IDX         16'hdf15
`define STATUS_IDX      16'hdf3d
`define EXIT_ADDR       {`EXIT_IDX, 2'h0}
`define CALCFG_ADDR     {`CALCFG_IDX, 2'h0}
`define FOC_ADDR        {`FOC_IDX, 2'h0}
`define STATUS_ADDR     {`STATUS_IDX, 2'h0}

`define EXIT_RESET      8'h30
`define CALCFG_RESET    8'h04
`define FOC_RESET       8'h76
`define EXIT_WMASK      8'h3f
`define CALCFG_WMASK    8'h3f
`define FOC_WMASK       8'h7f

`define CCA_LSB         4
`define RXOFF_LSB       2
`define TXOFF_LSB       0
`define AUTOCAL_LSB     4
`define ATTEN_LSB       0
`define GATE_BIT        5
`define PREK_LSB        3
`define POSTK_BIT       2
`define LIMIT_LSB       0

`define CAL_NEVER       2'h0
`define CAL_ON_EXIT     2'h1
`define CAL_ON_RETURN   2'h2
`define CAL_EVERY_4TH   2'h3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define CLK_PERIOD_NS   50
`define CAL_TIME_NS     800
`define CAL_CYCLES      ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** src/radio_cfg_pkg.sv ***
// Types of the radio state control block.
// Assumes radio_cfg_defines.svh for all numeric constants.
package radio_cfg_pkg;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_RX     = 5'h02,
		ST_TX     = 5'h04,
		ST_SYNTH_ON_READY_TX = 5'h08,
		ST_CAL    = 5'h10
	} radio_state_t;

	typedef struct packed {
		logic [7:0]   exit_cfg;
		logic [7:0]   cal_cfg;
		logic [7:0]   foc_cfg;
		logic         aw_rdy;
		logic         w_rdy;
		logic         b_vld;
		logic [1:0]   b_resp;
		logic [17:0]  aw_addr;
		logic [31:0]  w_data;
		logic [3:0]   w_strb;
		logic         ar_rdy;
		logic         r_vld;
		logic [1:0]   r_resp;
		logic [31:0]  r_data;
		radio_state_t state;
		radio_state_t target;
		logic [4:0]   cal_cnt;
		logic         calibrating;
		logic         preamble;
		logic         cca;
		logic [4:0]   atten;
	} top_state_t;

	typedef struct packed {
		logic [1:0] returns;
		logic       on_exit;
		logic       on_return;
	} cal_state_t;

	typedef struct packed {
		logic       seen;
		logic       frozen;
		logic [3:0] gain;
		logic       enable;
		logic [1:0] shift;
	} foc_state_t;
endpackage

// *** src/radio_ctl_if.sv ***
// Signals between the radio control top and its two helper units.
// Assumes all three sit on one clock.
`timescale 1ns/100ps
interface radio_ctl_if;
	logic [1:0] policy;
	logic       auto_return;
	logic       on_exit;
	logic       on_return;
	logic [1:0] returns;
	logic [7:0] foc_cfg;
	logic       rx_active;
	logic       carrier;
	logic       sync;
	logic       frozen;
	logic       enable;
	logic [3:0] gain;
	logic [1:0] shift;

	modport cal  (input policy, auto_return, output on_exit, on_return, returns);
	modport foc  (input foc_cfg, rx_active, carrier, sync, output frozen, enable, gain, shift);
	modport ctrl (output policy, auto_return, foc_cfg, rx_active, carrier, sync,
		input on_exit, on_return, returns, frozen, enable, gain, shift);
endinterface // radio_ctl_if

// *** src/synth_cal_policy.sv ***
// Decides when the synthesizer calibrates automatically.
// Assumes auto_return is a one-cycle pulse per automatic return to idle.
`timescale 1ns/100ps
`include "radio_cfg_defines.svh"
module synth_cal_policy (
	input wire logic clk,
	input wire logic rst,
	radio_ctl_if.cal ctl
);
	radio_cfg_pkg::cal_state_t q;
	radio_cfg_pkg::cal_state_t d;

	// Flags are precomputed so the main state machine never waits on them
	always_comb begin
		d = q;
		if (ctl.auto_return) begin
			d.returns = q.returns + 2'h1;
		end
		d.on_exit   = (ctl.policy == `CAL_ON_EXIT);
		d.on_return = (ctl.policy == `CAL_ON_RETURN) ||
			((ctl.policy == `CAL_EVERY_4TH) && (d.returns == 2'h3));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ctl.on_exit   = q.on_exit;
	assign ctl.on_return = q.on_return;
	assign ctl.returns   = q.returns;
endmodule // synth_cal_policy

// *** src/offset_loop_ctl.sv ***
// Gain, limit and freeze control of the frequency offset loop.
// Assumes carrier and sync are levels from the demodulator on this clock.
`timescale 1ns/100ps
`include "radio_cfg_defines.svh"
module offset_loop_ctl (
	input wire logic clk,
	input wire logic rst,
	radio_ctl_if.foc ctl
);
	radio_cfg_pkg::foc_state_t q;
	radio_cfg_pkg::foc_state_t d;
	logic [3:0]                pre_gain;

	// Gain is given in units of K/2 so that K/2 stays an integer
	always_comb begin
		d = q;
		pre_gain = {1'b0, ctl.foc_cfg[`PREK_LSB +: 2], 1'b0} + 4'h2;
		d.seen   = ctl.rx_active && (q.seen || ctl.carrier);
		d.frozen = ctl.foc_cfg[`GATE_BIT] && !d.seen;
		d.gain = pre_gain;
		if (ctl.sync && ctl.foc_cfg[`POSTK_BIT]) begin
			d.gain = 4'h1;
		end
		d.enable = (ctl.foc_cfg[`LIMIT_LSB +: 2] != 2'h0);
		unique case (ctl.foc_cfg[`LIMIT_LSB +: 2])
			2'h1:    d.shift = 2'h3;
			2'h2:    d.shift = 2'h2;
			2'h3:    d.shift = 2'h1;
			default: d.shift = 2'h0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ctl.frozen = q.frozen;
	assign ctl.enable = q.enable;
	assign ctl.gain   = q.gain;
	assign ctl.shift  = q.shift;
endmodule // offset_loop_ctl

// *** bench/rscc_asserts.sv ***
// Port-level checks of the radio state control top.
// Assumes a bind onto radio_state_control_config; one clock, reset rst.
`timescale 1ns/100ps
module rscc_asserts (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic             s_axi_rvalid,
	input wire logic             tx_packet_done,
	input wire logic             carrier_detected,
	input radio_cfg_pkg::radio_state_t radio_state,
	input wire logic             synth_calibrating,
	input wire logic             preamble_restart,
	input wire logic [4:0]       rx_atten_db,
	input wire logic             loops_frozen,
	input wire logic [3:0]       offset_gain_half_k,
	input wire logic             offset_comp_enable,
	input wire logic [1:0]       offset_limit_shift
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// Length of each calibration; a repetition of 16 would be too costly to unroll
	logic [4:0] cal_len_q;
	logic [4:0] cal_len_d;
	always_comb cal_len_d = synth_calibrating ? cal_len_q + 5'h01 : 5'h00;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_len_q <= 5'h00;
		end else begin
			cal_len_q <= cal_len_d;
		end
	end

	// Bus answers
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read upper bits set");
	// Write lands one edge after both halves are held, the answer is seen at the edge after that
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	// Radio side
	chk_cal_state: assert property (synth_calibrating == (radio_state == radio_cfg_pkg::ST_CAL))
		else $error("calibrate flag and state differ");
	chk_cal_length: assert property ($fell(synth_calibrating) |-> cal_len_q == 5'h10)
		else $error("calibration length wrong");
	chk_preamble_tx: assert property (preamble_restart |-> radio_state == radio_cfg_pkg::ST_TX && $past(tx_packet_done))
		else $error("preamble restart out of place");
	chk_atten_step: assert property (rx_atten_db inside {5'h00, 5'h06, 5'h0c, 5'h12})
		else $error("attenuation not a step");
	chk_limit_enable: assert property (offset_comp_enable == (offset_limit_shift != 2'h0))
		else $error("limit and enable differ");
	chk_gain_range: assert property (!$past(rst) |-> offset_gain_half_k inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
		else $error("loop gain out of range");
	chk_carrier_unfreeze: assert property (radio_state == radio_cfg_pkg::ST_RX && carrier_detected
		|-> ##[1:2] !loops_frozen)
		else $error("loops stay frozen under carrier");
endmodule // rscc_asserts

// *** bench/testbench.sv ***
// Self-checking bench of the radio state control top.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`include "radio_cfg_defines.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
	logic        clk, rst = 1;
	logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
	logic [6:0]  ev = 0;
	logic        rssi_below_threshold = 0, packet_receiving = 0, carrier_detected = 0, sync_detected = 0;
	logic        strobe_rx, strobe_tx, strobe_synth_on_ready_tx, strobe_idle, calibrate_strobe, rx_packet_done, tx_packet_done;
	logic        synth_calibrating, preamble_restart, clear_channel, loops_frozen, offset_comp_enable, p;
	logic [4:0]  rx_atten_db;
	logic [3:0]  offset_gain_half_k;
	logic [1:0]  offset_limit_shift;
	logic [7:0]  d;
	logic [33:0] er;
	logic [33:0] exp_r[$];
	logic [1:0]  exp_b[$];
	int          n_mismatch = 0, comparisons = 0, nret = 0;
	radio_cfg_pkg::radio_state_t radio_state;
	radio_cfg_pkg::radio_state_t tab[4] = '{radio_cfg_pkg::ST_IDLE, radio_cfg_pkg::ST_SYNTH_ON_READY_TX,
		radio_cfg_pkg::ST_TX, radio_cfg_pkg::ST_RX};
	logic [17:0] ad[3] = '{`EXIT_ADDR, `CALCFG_ADDR, `FOC_ADDR};
	logic [7:0]  mk[3] = '{8'h3f, 8'h3f, 8'h3f};

	assign {strobe_rx, strobe_tx, strobe_synth_on_ready_tx, strobe_idle, calibrate_strobe, rx_packet_done, tx_packet_done} = ev;
	radio_state_control_config i_radio_state_control_config (
		.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.strobe_rx(strobe_rx), .strobe_tx(strobe_tx), .strobe_synth_on_ready_tx(strobe_synth_on_ready_tx), .strobe_idle(strobe_idle),
		.calibrate_strobe(calibrate_strobe), .rx_packet_done(rx_packet_done), .tx_packet_done(tx_packet_done),
		.rssi_below_threshold(rssi_below_threshold), .packet_receiving(packet_receiving),
		.carrier_detected(carrier_detected), .sync_detected(sync_detected), .radio_state(radio_state),
		.synth_calibrating(synth_calibrating), .preamble_restart(preamble_restart), .clear_channel(clear_channel),
		.rx_atten_db(rx_atten_db), .loops_frozen(loops_frozen), .offset_gain_half_k(offset_gain_half_k),
		.offset_comp_enable(offset_comp_enable), .offset_limit_shift(offset_limit_shift)
	);

	// Clock of 50 ns
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 40) begin
			n_mismatch++;
			$display("[FAIL] wait exp done got hang");
			test_done();
		end
	endtask

	// Both write channels offered together, each released once taken
	task automatic wr(input logic [17:0] a, input logic [7:0] v, input logic [1:0] e);
		int n = 0;
		@(posedge clk);
		exp_b.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid && n < 40);
		s_axi_bready <= 0;
		tmo(n);
	endtask

	task automatic rd(input logic [17:0] a, input logic [7:0] v, input logic [1:0] e);
		int n = 0;
		@(posedge clk);
		exp_r.push_back({e, 24'h00_0000, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid && n < 40);
		s_axi_rready <= 0;
		tmo(n);
	endtask

	// One-cycle event, state looked at once it has landed
	task automatic step(input int i, input radio_cfg_pkg::radio_state_t e);
		@(posedge clk);
		ev[i] <= 1;
		@(posedge clk);
		ev[i] <= 0;
		@(negedge clk);
		`CHK("state", e, radio_state)
		`CHK("cal flag", 1'(e == radio_cfg_pkg::ST_CAL), synth_calibrating)
	endtask

	task automatic wait_cal(input radio_cfg_pkg::radio_state_t e);
		int n = 0;
		while (radio_state === radio_cfg_pkg::ST_CAL && n < 40) begin
			@(negedge clk);
			n++;
		end
		tmo(n);
		`CHK("after cal", e, radio_state)
	endtask

	// Bus answers are compared against the oldest note
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			er = exp_r.pop_front();
			`CHK("rd", er, {s_axi_rresp, s_axi_rdata})
		end
		if (s_axi_bvalid && s_axi_bready) begin
			eb = exp_b.pop_front();
			`CHK("bresp", eb, s_axi_bresp)
		end
	end

	initial begin
		void'($urandom(6158));
		repeat (20) @(posedge clk);
		rst <= 0;
		// Reset values, refusals, writable masks
		rd(`EXIT_ADDR, 8'h30, `RESP_OKAY);
		rd(`CALCFG_ADDR, 8'h04, `RESP_OKAY);
		rd(`FOC_ADDR, 8'h76, `RESP_OKAY);
		rd(18'h0_0010, 8'h00, `RESP_SLVERR);
		wr(18'h0_0010, 8'h55, `RESP_SLVERR);
		wr(`STATUS_ADDR, 8'hff, `RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			// bit six of the offset register goes out as zero
			wr(ad[i], i == 2 ? 8'hbf : 8'hff, `RESP_OKAY);
			rd(ad[i], mk[i], `RESP_OKAY);
		end
		// Every clear channel mode against every input pair
		for (int m = 0; m < 4; m++) begin
			wr(`EXIT_ADDR, 8'(m << 4), `RESP_OKAY);
			for (int c = 0; c < 4; c++) begin
				@(posedge clk);
				{rssi_below_threshold, packet_receiving} <= 2'(c);
				repeat (2) @(negedge clk);
				`CHK("cca", 1'((!m[0] || c[1]) && (!m[1] || !c[0])), clear_channel)
			end
		end
		// Random calibration config words, attenuation follows
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom());
			wr(`CALCFG_ADDR, d, `RESP_OKAY);
			rd(`CALCFG_ADDR, d & 8'h3f, `RESP_OKAY);
			`CHK("atten", 5'(d[1:0] * 6), rx_atten_db)
		end
		wr(`CALCFG_ADDR, 8'h00, `RESP_OKAY);
		// Exit state after receive (k 0) and after send (k 1)
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 2; k++) begin
				// exits to TX or SYNTH_ON_READY_TX only with clear channel code 00
				wr(`EXIT_ADDR, 8'(k ? m : m << 2), `RESP_OKAY);
				step(k ? 5 : 6, k ? radio_cfg_pkg::ST_TX : radio_cfg_pkg::ST_RX);
				step(k ? 0 : 1, tab[m]);
				if (k) `CHK("preamble", 1'(m == 2), preamble_restart)
				nret += (m == 0);
				step(3, radio_cfg_pkg::ST_IDLE);
			end
		end
		// Calibration policies; the return counter runs under every policy
		wr(`CALCFG_ADDR, 8'h10, `RESP_OKAY);
		step(6, radio_cfg_pkg::ST_CAL);
		wait_cal(radio_cfg_pkg::ST_RX);
		step(3, radio_cfg_pkg::ST_IDLE);
		wr(`CALCFG_ADDR, 8'h00, `RESP_OKAY);
		step(6, radio_cfg_pkg::ST_RX);
		step(3, radio_cfg_pkg::ST_IDLE);
		step(2, radio_cfg_pkg::ST_CAL);
		wait_cal(radio_cfg_pkg::ST_IDLE);
		wr(`EXIT_ADDR, 8'h00, `RESP_OKAY);
		wr(`CALCFG_ADDR, 8'h20, `RESP_OKAY);
		step(6, radio_cfg_pkg::ST_RX);
		step(1, radio_cfg_pkg::ST_CAL);
		nret++;
		wait_cal(radio_cfg_pkg::ST_IDLE);
		wr(`CALCFG_ADDR, 8'h30, `RESP_OKAY);
		repeat (4) begin
			step(6, radio_cfg_pkg::ST_RX);
			nret++;
			step(1, nret % 4 == 0 ? radio_cfg_pkg::ST_CAL : radio_cfg_pkg::ST_IDLE);
			wait_cal(radio_cfg_pkg::ST_IDLE);
		end
		// Offset loop gain and limit for every code, post gain bit random
		for (int k = 0; k < 4; k++) begin
			p = 1'($urandom());
			// limit code 00 is the setting an ASK user keeps
			wr(`FOC_ADDR, 8'(k << 3 | p << 2 | k), `RESP_OKAY);
			repeat (2) @(negedge clk);
			`CHK("gain", 4'(2 * k + 2), offset_gain_half_k)
			`CHK("limit", 2'(k == 0 ? 0 : 4 - k), offset_limit_shift)
			`CHK("enable", 1'(k != 0), offset_comp_enable)
			@(posedge clk);
			sync_detected <= 1;
			repeat (2) @(negedge clk);
			`CHK("post gain", 4'(p ? 1 : 2 * k + 2), offset_gain_half_k)
			@(posedge clk);
			sync_detected <= 0;
		end
		// Carrier gate holds the loops until carrier appears
		wr(`FOC_ADDR, 8'h36, `RESP_OKAY);
		step(6, radio_cfg_pkg::ST_RX);
		repeat (2) @(negedge clk);
		`CHK("frozen", 1'b1, loops_frozen)
		@(posedge clk);
		carrier_detected <= 1;
		repeat (3) @(negedge clk);
		`CHK("released", 1'b0, loops_frozen)
		test_done();
	end
endmodule // testbench

bind radio_state_control_config rscc_asserts i_rscc_asserts (
	.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.tx_packet_done(tx_packet_done), .carrier_detected(carrier_detected), .radio_state(radio_state),
	.synth_calibrating(synth_calibrating), .preamble_restart(preamble_restart), .rx_atten_db(rx_atten_db),
	.loops_frozen(loops_frozen), .offset_gain_half_k(offset_gain_half_k),
	.offset_comp_enable(offset_comp_enable), .offset_limit_shift(offset_limit_shift)
);
